// [pcsp_pkg.sv]
`default_nettype none

package pcsp_pkg;

  // Serial word widths, parallel sample width and bit counter width
  localparam int LINEAR_BITS = 15;
  localparam int COMPAND_BITS = 8;
  localparam int SAMPLE_W = 16;
  localparam int CNT_W = 5;

  // Clock and timing figures
  localparam int REF_CLK_HZ = 100_000_000;
  localparam int RESET_MIN_NS = 500;
  localparam int RESET_MIN_CYCLES = (RESET_MIN_NS * (REF_CLK_HZ / 1_000_000)
                                     + 999) / 1000;
  localparam int BIT_CLK_FAST_HZ = 2_048_000;
  localparam int BIT_CLK_SLOW_HZ = 128_000;
  localparam int FRAME_HZ = 8_000;

  // Cycles after reset release before the power select is trusted
  localparam logic [1:0] INIT_WAIT = 2'h3;

  // Companding constants
  localparam logic [15:0] MU_BIAS_ENC = 16'h0021;
  localparam logic [15:0] MU_CLIP = 16'h1fff;
  localparam logic [15:0] MU_BIAS_DEC = 16'h0084;
  localparam logic [15:0] A_CLIP = 16'h0fff;
  localparam logic [15:0] A_SEG0_ROUND = 16'h0008;
  localparam logic [15:0] A_SEG_BIAS = 16'h0108;
  localparam logic [7:0] A_TOGGLE = 8'h55;

  typedef struct packed {
    logic power_down;
    logic companded;
    logic a_law;
  } pcsp_cfg_t;

  // Defaults: linear words, mu-law when companding is selected
  localparam logic CFG_COMPANDED_RST = 1'b0;
  localparam logic CFG_A_LAW_RST = 1'b0;

endpackage : pcsp_pkg

`default_nettype wire

// [pcsp_serial_port.sv]
// Summary of operation
// R1: Linear 15-bit or 8-bit companded words, mu-law or A-law.
// R2: Bit clock is 128 kHz or 2.048 MHz from the master.
// R3: Power select low powers down on reset, high powers up.
// R4: Master holds reset low at least 500 ns.
// R5: Reset loads defaults that allow operation with no programming.
// R6: Codec is slave; master drives bit clock and 8 kHz frame sync.
// R7: Words are left-justified in both directions.
// R8: Captured samples go out serially; playback samples come in serially.
// R9: Control writes replace the reset defaults.
// R10: One sample each way per frame sync period.
// R11: MSB first from the edge after frame sync; master samples opposite edge.
`timescale 1ns/1ps
`default_nettype none

module pcsp_serial_port (
  input wire logic REF_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic POWER_UP_SELECT_IN,
  input wire logic BIT_CLK_IN,
  input wire logic FRAME_SYNC_IN,
  input wire logic SERIAL_DATA_IN,
  output logic SERIAL_DATA_OUT,
  input wire logic [15:0] ADC_SAMPLE_IN,
  output logic ADC_TAKEN_OUT,
  output logic [15:0] DAC_SAMPLE_OUT,
  output logic DAC_VALID_OUT,
  input wire logic CFG_WR_IN,
  input wire pcsp_pkg::pcsp_cfg_t CFG_IN,
  output logic POWERED_DOWN_OUT
);

  typedef struct packed {
    logic [1:0] bclk_s;
    logic bclk_d;
    logic [1:0] fs_s;
    logic fs_d;
    logic [1:0] din_s;
    logic [1:0] sel_s;
    logic [1:0] init_cnt;
    pcsp_pkg::pcsp_cfg_t cfg;
    logic [15:0] tx_sh;
    logic [4:0] tx_cnt;
    logic [15:0] rx_sh;
    logic [4:0] rx_cnt;
    logic rx_active;
    logic dout;
    logic adc_taken;
    logic [15:0] dac_sample;
    logic dac_valid;
  } pcsp_state_t;

  pcsp_state_t st_r;
  pcsp_state_t st_nxt;

  function automatic logic [7:0] pcsp_mu_enc(input logic [15:0] x);
    logic [15:0] mag;
    logic [12:0] v;
    logic [2:0] seg;
    logic [3:0] mant;
    mag = x[15] ? 16'(-x) : x;
    mag = (mag >> 2) + pcsp_pkg::MU_BIAS_ENC;
    if (mag > pcsp_pkg::MU_CLIP) begin
      mag = pcsp_pkg::MU_CLIP;
    end
    v = mag[12:0];
    seg = 3'h0;
    for (int i = 6; i <= 12; i++) begin
      if (v[i]) begin
        seg = 3'(i - 5);
      end
    end
    mant = 4'(v >> ({1'b0, seg} + 4'h1));
    return {~x[15], ~seg, ~mant};
  endfunction : pcsp_mu_enc

  function automatic logic [7:0] pcsp_a_enc(input logic [15:0] x);
    logic [15:0] mag;
    logic [11:0] v;
    logic [2:0] seg;
    logic [3:0] mant;
    mag = x[15] ? 16'(-x) : x;
    mag = mag >> 3;
    if (mag > pcsp_pkg::A_CLIP) begin
      mag = pcsp_pkg::A_CLIP;
    end
    v = mag[11:0];
    seg = 3'h0;
    for (int i = 5; i <= 11; i++) begin
      if (v[i]) begin
        seg = 3'(i - 4);
      end
    end
    mant = (seg == 3'h0) ? v[4:1] : 4'(v >> seg);
    return {~x[15], seg, mant} ^ pcsp_pkg::A_TOGGLE;
  endfunction : pcsp_a_enc

  function automatic logic [15:0] pcsp_mu_dec(input logic [7:0] code);
    logic [7:0] u;
    logic [15:0] t;
    u = ~code;
    t = ({9'h000, u[3:0], 3'h0} + pcsp_pkg::MU_BIAS_DEC) << u[6:4];
    return u[7] ? 16'(pcsp_pkg::MU_BIAS_DEC - t)
                : 16'(t - pcsp_pkg::MU_BIAS_DEC);
  endfunction : pcsp_mu_dec

  function automatic logic [15:0] pcsp_a_dec(input logic [7:0] code);
    logic [7:0] a;
    logic [15:0] t;
    a = code ^ pcsp_pkg::A_TOGGLE;
    t = {8'h00, a[3:0], 4'h0};
    if (a[6:4] == 3'h0) begin
      t = t + pcsp_pkg::A_SEG0_ROUND;
    end else begin
      t = (t + pcsp_pkg::A_SEG_BIAS) << (a[6:4] - 3'h1);
    end
    return a[7] ? t : 16'(-t);
  endfunction : pcsp_a_dec

  logic bclk_rise;
  logic bclk_fall;
  logic frame_start;
  logic [4:0] word_len;

  always_comb begin
    st_nxt = st_r;
    st_nxt.adc_taken = 1'b0;
    st_nxt.dac_valid = 1'b0;
    // Bit clock is oversampled; the first flop feeds only the second
    st_nxt.bclk_s = {st_r.bclk_s[0], BIT_CLK_IN}; // R2
    st_nxt.bclk_d = st_r.bclk_s[1];
    st_nxt.fs_s = {st_r.fs_s[0], FRAME_SYNC_IN};
    st_nxt.din_s = {st_r.din_s[0], SERIAL_DATA_IN};
    // Select pin is a board level, so it gets the same two-flop guard
    st_nxt.sel_s = {st_r.sel_s[0], POWER_UP_SELECT_IN};
    bclk_rise = st_r.bclk_s[1] & ~st_r.bclk_d;
    bclk_fall = ~st_r.bclk_s[1] & st_r.bclk_d;
    // Frame begins at the first rising edge that sees sync high
    frame_start = bclk_rise & st_r.fs_s[1] & ~st_r.fs_d; // R10 R6
    word_len = st_r.cfg.companded ? 5'(pcsp_pkg::COMPAND_BITS)
                                  : 5'(pcsp_pkg::LINEAR_BITS); // R1
    if (bclk_rise) begin
      st_nxt.fs_d = st_r.fs_s[1];
    end
    // Power state is taken from the select pin once, after the sync chain has settled
    if (st_r.init_cnt != 2'h0) begin
      st_nxt.init_cnt = st_r.init_cnt - 2'h1;
      if (st_r.init_cnt == 2'h1) begin
        st_nxt.cfg.power_down = ~st_r.sel_s[1]; // R3
      end
    end else if (CFG_WR_IN) begin
      st_nxt.cfg = CFG_IN; // R9
    end
    if (st_r.cfg.power_down || st_r.init_cnt != 2'h0) begin
      st_nxt.dout = 1'b0;
      st_nxt.tx_cnt = 5'h00;
      st_nxt.rx_active = 1'b0;
    end else begin
      if (frame_start) begin
        // Word is left-justified; the sample is held for the whole frame
        if (st_r.cfg.companded) begin // R7
          st_nxt.tx_sh = {(st_r.cfg.a_law ? pcsp_a_enc(ADC_SAMPLE_IN)
                                          : pcsp_mu_enc(ADC_SAMPLE_IN)),
                          8'h00}; // R1
        end else begin
          st_nxt.tx_sh = ADC_SAMPLE_IN; // R7
        end
        st_nxt.tx_cnt = word_len;
        st_nxt.adc_taken = 1'b1; // R8
        st_nxt.dout = 1'b0;
        st_nxt.rx_cnt = 5'h00;
        st_nxt.rx_active = 1'b1;
      end
      // MSB leaves on the rising edge after the frame edge
      if (bclk_rise && !frame_start) begin // R11
        if (st_r.tx_cnt != 5'h00) begin
          st_nxt.dout = st_r.tx_sh[15];
          st_nxt.tx_sh = {st_r.tx_sh[14:0], 1'b0};
          st_nxt.tx_cnt = st_r.tx_cnt - 5'h01;
        end else begin
          st_nxt.dout = 1'b0;
        end
      end
      // Playback bits are taken on falling edges, opposite the drive edge
      if (bclk_fall && st_r.rx_active && st_r.tx_cnt != word_len) begin // R11
        st_nxt.rx_sh = {st_r.rx_sh[14:0], st_r.din_s[1]}; // R8
        st_nxt.rx_cnt = st_r.rx_cnt + 5'h01;
        if (st_r.rx_cnt + 5'h01 == word_len) begin
          st_nxt.rx_active = 1'b0; // R10
          st_nxt.dac_valid = 1'b1;
          if (st_r.cfg.companded) begin
            st_nxt.dac_sample = st_r.cfg.a_law
                ? pcsp_a_dec({st_r.rx_sh[6:0], st_r.din_s[1]})
                : pcsp_mu_dec({st_r.rx_sh[6:0], st_r.din_s[1]}); // R1
          end else begin
            st_nxt.dac_sample = {st_r.rx_sh[13:0], st_r.din_s[1],
                                 1'b0}; // R7
          end
        end
      end
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      // Defaults let the port run with no programming when the select pin is high
      st_r <= '0; // R5
      st_r.init_cnt <= pcsp_pkg::INIT_WAIT;
      st_r.cfg.power_down <= 1'b1;
      st_r.cfg.companded <= pcsp_pkg::CFG_COMPANDED_RST;
      st_r.cfg.a_law <= pcsp_pkg::CFG_A_LAW_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign SERIAL_DATA_OUT = st_r.dout;
  assign ADC_TAKEN_OUT = st_r.adc_taken;
  assign DAC_SAMPLE_OUT = st_r.dac_sample;
  assign DAC_VALID_OUT = st_r.dac_valid;
  assign POWERED_DOWN_OUT = st_r.cfg.power_down;

endmodule : pcsp_serial_port

`default_nettype wire

// [pcsp_sp_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module pcsp_sp_checker (
  input wire logic REF_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic POWER_UP_SELECT_IN,
  input wire logic FRAME_SYNC_IN,
  input wire logic SERIAL_DATA_OUT,
  input wire logic ADC_TAKEN_OUT,
  input wire logic [15:0] DAC_SAMPLE_OUT,
  input wire logic DAC_VALID_OUT,
  input wire logic CFG_WR_IN,
  input wire pcsp_pkg::pcsp_cfg_t CFG_IN,
  input wire logic POWERED_DOWN_OUT
);
  // Cycles since release; writes count only once init is surely over
  logic [2:0] up_r;
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) up_r <= 3'h0;
    else if (up_r != 3'h4) up_r <= up_r + 3'h1;
  end
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  sequence s_release;
    $rose(RST_N_IN) ##4 1'b1;
  endsequence
  sequence s_frame;
    $rose(FRAME_SYNC_IN) && !POWERED_DOWN_OUT;
  endsequence
  a_reset_clears: assert property (disable iff (1'b0) !RST_N_IN |=>
    !SERIAL_DATA_OUT && !ADC_TAKEN_OUT && !DAC_VALID_OUT &&
    POWERED_DOWN_OUT && DAC_SAMPLE_OUT == 16'h0000) else $error("reset");
  a_select_hold: assert property ($rose(RST_N_IN) |->
    POWERED_DOWN_OUT [*2]) else $error("early power state");
  a_select_apply: assert property (s_release |->
    POWERED_DOWN_OUT == !POWER_UP_SELECT_IN) else $error("power select");
  a_cfg_takes: assert property (CFG_WR_IN && up_r == 3'h4 |=>
    POWERED_DOWN_OUT == $past(CFG_IN.power_down)) else $error("cfg write");
  a_cfg_hold: assert property (!CFG_WR_IN && up_r == 3'h4 |=>
    $stable(POWERED_DOWN_OUT)) else $error("power state moved");
  a_taken_once: assert property (ADC_TAKEN_OUT |=> !ADC_TAKEN_OUT)
    else $error("taken pulse");
  a_valid_once: assert property (DAC_VALID_OUT |=> !DAC_VALID_OUT)
    else $error("valid pulse");
  a_frame_taken: assert property (s_frame |-> ##[2:14] ADC_TAKEN_OUT)
    else $error("frame not taken");
  a_down_quiet: assert property (POWERED_DOWN_OUT &&
    $past(POWERED_DOWN_OUT) |-> !ADC_TAKEN_OUT && !DAC_VALID_OUT)
    else $error("traffic while down");
  a_idle_low: assert property (ADC_TAKEN_OUT |-> !SERIAL_DATA_OUT)
    else $error("line not idle");
  a_dac_hold: assert property (!DAC_VALID_OUT |->
    $stable(DAC_SAMPLE_OUT)) else $error("sample moved");
endmodule : pcsp_sp_checker
bind pcsp_serial_port pcsp_sp_checker chk_u (.REF_CLK_IN(REF_CLK_IN),
  .RST_N_IN(RST_N_IN), .POWER_UP_SELECT_IN(POWER_UP_SELECT_IN),
  .FRAME_SYNC_IN(FRAME_SYNC_IN), .SERIAL_DATA_OUT(SERIAL_DATA_OUT),
  .ADC_TAKEN_OUT(ADC_TAKEN_OUT), .DAC_SAMPLE_OUT(DAC_SAMPLE_OUT),
  .DAC_VALID_OUT(DAC_VALID_OUT), .CFG_WR_IN(CFG_WR_IN), .CFG_IN(CFG_IN),
  .POWERED_DOWN_OUT(POWERED_DOWN_OUT));
`default_nettype wire

// [pcsp_master_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pcsp_master_model (
  input wire logic go_in,
  input wire logic [15:0] word_in,
  input wire logic [4:0] len_in,
  input wire logic sdo_in,
  output logic bclk_out,
  output logic sync_out,
  output logic sdi_out,
  output logic busy_out,
  output logic [15:0] rx_out
);
  initial begin
    bclk_out = 1'b0;
    sync_out = 1'b0;
    sdi_out = 1'b0;
    busy_out = 1'b0;
    rx_out = 16'h0000;
  end
  // Bit clock stands still between frames
  always @(posedge go_in) begin : frame_b
    int k;
    busy_out = 1'b1;
    sync_out = 1'b1;
    #40;
    for (k = 0; k <= len_in + 1; k++) begin
      bclk_out = 1'b1;
      if (k == 1) sync_out = 1'b0;
      if (k >= 1 && k <= len_in) sdi_out = word_in[16-k];
      else sdi_out = ~sdi_out;
      #40;
      bclk_out = 1'b0;
      if (k >= 1 && k <= len_in) rx_out = {rx_out[14:0], sdo_in};
      #40;
    end
    busy_out = 1'b0;
  end
endmodule : pcsp_master_model
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst_n, sel, sdo, taken, valid, wr, pd, go, bclk, sync, sdi, busy;
  logic [15:0] adc, dac, word, rx;
  logic [4:0] len;
  pcsp_pkg::pcsp_cfg_t cfg_v;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  pcsp_serial_port dut_u (.REF_CLK_IN(clk), .RST_N_IN(rst_n),
    .POWER_UP_SELECT_IN(sel), .BIT_CLK_IN(bclk), .FRAME_SYNC_IN(sync),
    .SERIAL_DATA_IN(sdi), .SERIAL_DATA_OUT(sdo), .ADC_SAMPLE_IN(adc),
    .ADC_TAKEN_OUT(taken), .DAC_SAMPLE_OUT(dac), .DAC_VALID_OUT(valid),
    .CFG_WR_IN(wr), .CFG_IN(cfg_v), .POWERED_DOWN_OUT(pd));
  pcsp_master_model pm_u (.go_in(go), .word_in(word), .len_in(len),
    .sdo_in(sdo), .bclk_out(bclk), .sync_out(sync), .sdi_out(sdi),
    .busy_out(busy), .rx_out(rx));
  task chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      $display("FAIL %0t %s", $time, m);
      err_count++;
    end
  endtask : chk
  task report_and_stop;
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  task do_reset(input logic s, input int n);
    rst_n = 1'b0;
    sel = s;
    repeat (n) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask : do_reset
  task do_cfg(input logic p, input logic c, input logic a);
    cfg_v = {p, c, a};
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
    chk(pd === p, "power state");
  endtask : do_cfg
  // Counts pulses over the whole frame so a double word is seen
  task frame(input logic [15:0] w, input logic [4:0] n, output int nv,
             output int nt);
    int i;
    word = w;
    len = n;
    nv = 0;
    nt = 0;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    for (i = 0; i < 600 && busy !== 1'b0; i++) begin
      @(negedge clk);
      nv += (valid === 1'b1);
      nt += (taken === 1'b1);
    end
  endtask : frame
  task t_linear;
    int nv, nt;
    adc = 16'hb5a7;
    frame(16'h9d37, 5'd15, nv, nt);
    chk(nv == 1 && nt == 1, "one word each way");
    chk(rx[14:0] === adc[15:1], "linear out");
    chk(dac === 16'h9d36, "linear in");
    chk(sdo === 1'b0, "line idle");
  endtask : t_linear
  task t_compand(input logic a, input logic [7:0] code,
                 input logic [15:0] exp);
    int nv, nt;
    adc = 16'h0000;
    do_cfg(1'b0, 1'b1, a);
    frame({code, 8'h00}, 5'd8, nv, nt);
    chk(nv == 1 && rx[7:0] === code, "companded out");
    chk(dac === exp, "companded in");
  endtask : t_compand
  task t_down;
    int nv, nt;
    do_cfg(1'b1, 1'b0, 1'b0);
    frame(16'hffff, 5'd15, nv, nt);
    chk(nv == 0 && nt == 0, "frames refused");
  endtask : t_down
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      report_and_stop;
    end
  end
  initial begin
    rst_n = 1'b0;
    sel = 1'b1;
    wr = 1'b0;
    cfg_v = 3'h0;
    adc = 16'h0000;
    go = 1'b0;
    word = 16'h0000;
    len = 5'h00;
    do_reset(1'b1, 4);
    chk(pd === 1'b0, "power up");
    t_linear;
    t_compand(1'b0, 8'hff, 16'h0000);
    t_compand(1'b1, 8'hd5, 16'h0008);
    t_down;
    do_reset(1'b0, pcsp_pkg::RESET_MIN_CYCLES);
    chk(pd === 1'b1 && dac === 16'h0000, "reset state");
    do_cfg(1'b0, 1'b0, 1'b0);
    report_and_stop;
  end
endmodule : testbench
`default_nettype wire
